//--- include/pcfm_pkg.sv
// Package for the capability field map: layout, offsets and encodings
package pcfm_pkg;
  // Configuration dword indices of the structures
  localparam logic [9:0] PM_CAP_DW = 10'h010;
  localparam logic [9:0] PM_CSR_DW = 10'h011;
  localparam logic [9:0] MSI_CAP_DW = 10'h012;
  localparam logic [9:0] LINK_CAP_DW = 10'h01B;
  localparam logic [9:0] MSIX_CAP_DW = 10'h01C;
  localparam logic [9:0] MSIX_TBL_DW = 10'h01D;
  localparam logic [9:0] MSIX_PBA_DW = 10'h01E;
  localparam logic [9:0] DEV_CAP2_DW = 10'h021;
  localparam logic [9:0] RBAR_HDR_DW = 10'h040;
  localparam logic [9:0] RBAR_CAP0_DW = 10'h041;
  localparam logic [9:0] RBAR_CTL0_DW = 10'h042;
  localparam logic [9:0] RBAR_CAP1_DW = 10'h043;
  localparam logic [9:0] RBAR_CTL1_DW = 10'h044;
  // Capability identifiers
  localparam logic [7:0] MSI_ID = 8'h05;
  localparam logic [7:0] MSIX_ID = 8'h11;
  localparam logic [15:0] RBAR_ID = 16'h0015;
  // Field positions within a dword
  localparam int L0S_LSB = 12;
  localparam int L1_LSB = 15;
  localparam int CTO_OFF_BIT = 4;
  localparam int ATOM32_BIT = 7;
  localparam int ATOM64_BIT = 8;
  localparam int CAS128_BIT = 9;
  localparam int LTR_BIT = 11;
  localparam int TPH_BIT = 12;
  localparam int OBFF_LSB = 18;
  localparam int MSI_VEC_LSB = 17;
  localparam int MSIX_SIZE_LSB = 16;
  localparam int PMC_LSB = 16;
  localparam int PME_D3HOT_BIT = 30;
  localparam int PME_D1_BIT = 28;
  localparam int PME_D0_BIT = 27;
  localparam int D1_SUPP_BIT = 25;
  localparam int NO_SOFT_RST_BIT = 3;
  localparam int RBAR_VER_LSB = 16;
  localparam int RBAR_NEXT_LSB = 20;
  localparam int RBAR_SIZE_LSB = 4;
  localparam int RBAR_COUNT_LSB = 5;
  // Link rate codes
  typedef enum logic [1:0] {
    RATE_2G5 = 2'b00,
    RATE_5G = 2'b01,
    RATE_8G = 2'b10
  } pcfm_rate_e;
  // Host register byte offsets and fields
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_LINK = 8'h10;
  localparam int CMD_WE_BIT = 16;
  localparam int CMD_GO_BIT = 31;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int LINK_COMCLK_BIT = 2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

//--- include/pcfm_cfg_if.sv
// Configuration access link between controller and capability field map
`timescale 1ns/1ps
interface pcfm_cfg_if;
  logic req;
  logic we;
  logic [9:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  logic [1:0] link_rate;
  logic common_clk;
  modport dev (input req, input we, input addr, input wdata, input link_rate,
    input common_clk, output ack, output rdata);
  modport ctl (output req, output we, output addr, output wdata, output link_rate,
    output common_clk, input ack, input rdata);
endinterface

//--- verilog/pcfm_field_map.sv
// Capability field map: read-only configuration fields built from parameters
//
// Function
// - Report L0s exit latency for rate, clocking
// - Report L1 exit latency for rate, clocking
// - Completion timeout disable capability sets bit 4
// - Atomic completer support bits 7, 8, 9
// - Latency tolerance support sets bit 11
// - Processing hint completer support in bit 12
// - Flush/fill hint support in bits 19:18
// - Eight-bit next pointers; 00h ends list
// - Vector request code in control bits 19:17
// - Extended interrupt indicators, offsets; zero when disabled
// - Vector table size; user logic holds table
// - Wake support bits 14, 12, 11
// - D1 support sets power capability bit 9
// - No soft reset drives control bit 3
// - Resizable BAR structure absent when disabled
// - Resizable BAR count in control bits 7:5
// - First resizable index is the lowest
// - Second index zero or not below first
// - Size vectors keep unused positions zero
// - Twelve-bit extended next pointer; 000h ends
// - Power identifier, next pointer, version presented
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pcfm_field_map #(
  parameter logic [2:0] L0S_COM_2G5 = 3'h0,
  parameter logic [2:0] L0S_COM_5G = 3'h0,
  parameter logic [2:0] L0S_COM_8G = 3'h0,
  parameter logic [2:0] L0S_SEP_2G5 = 3'h0,
  parameter logic [2:0] L0S_SEP_5G = 3'h0,
  parameter logic [2:0] L0S_SEP_8G = 3'h0,
  parameter logic [2:0] L1_COM_2G5 = 3'h0,
  parameter logic [2:0] L1_COM_5G = 3'h0,
  parameter logic [2:0] L1_COM_8G = 3'h0,
  parameter logic [2:0] L1_SEP_2G5 = 3'h0,
  parameter logic [2:0] L1_SEP_5G = 3'h0,
  parameter logic [2:0] L1_SEP_8G = 3'h0,
  parameter bit completion_timeout_off_capable = 1'b0,
  parameter bit atomic32_completer = 1'b0,
  parameter bit atomic64_completer = 1'b0,
  parameter bit cas128_completer = 1'b0,
  parameter bit latency_tolerance_supported = 1'b0,
  parameter bit hint_completer_supported = 1'b0,
  parameter logic [1:0] flush_fill_hint_support = 2'h0,
  parameter logic [7:0] msg_irq_next_pointer = 8'h00,
  parameter logic [2:0] msg_irq_vector_request = 3'h0,
  parameter bit ext_irq_enable = 1'b0,
  parameter logic [7:0] ext_irq_next_pointer = 8'h00,
  parameter logic [2:0] pending_array_bar_indicator = 3'h0,
  parameter logic [28:0] pending_array_offset = 29'h0000_0000,
  parameter logic [2:0] vector_table_bar_indicator = 3'h0,
  parameter logic [28:0] vector_table_offset = 29'h0000_0000,
  parameter logic [10:0] vector_table_size = 11'h000,
  parameter logic [7:0] power_cap_identifier = 8'h01,
  parameter logic [7:0] power_cap_next_pointer = 8'h00,
  parameter logic [2:0] power_cap_spec_version = 3'h3,
  parameter bit wake_from_d3hot = 1'b0,
  parameter bit wake_from_d1 = 1'b0,
  parameter bit wake_from_d0 = 1'b0,
  parameter bit d1_state_supported = 1'b0,
  parameter bit keeps_state_on_d3_exit = 1'b0,
  parameter bit resizable_bar_enable = 1'b0,
  parameter logic [3:0] resizable_bar_version = 4'h1,
  parameter logic [11:0] resizable_bar_next_pointer = 12'h000,
  parameter logic [2:0] resizable_bar_count = 3'h0,
  parameter logic [2:0] resizable_bar_index_first = 3'h0,
  parameter logic [2:0] resizable_bar_index_second = 3'h0,
  parameter logic [19:0] resizable_bar_sizes_first = 20'h00000,
  parameter logic [19:0] resizable_bar_sizes_second = 20'h00000
) (
  input wire logic pclk,
  input wire logic presetn,
  pcfm_cfg_if.dev cfg
);

  // Picks the latency for rate and clocking; unknown rates fall back to 2.5 GT/s
  function automatic logic [2:0] pick_latency(input logic [1:0] rate, input logic com,
      input logic [2:0] c0, input logic [2:0] c1, input logic [2:0] c2,
      input logic [2:0] s0, input logic [2:0] s1, input logic [2:0] s2);
    logic [2:0] v;
    v = com ? c0 : s0;
    if (rate == pcfm_pkg::RATE_5G) begin
      v = com ? c1 : s1;
    end else if (rate == pcfm_pkg::RATE_8G) begin
      v = com ? c2 : s2;
    end
    return v;
  endfunction

  // Extended interrupt fields collapse to zero when the scheme is off
  localparam logic [2:0] PBA_BIR = ext_irq_enable ? pending_array_bar_indicator : 3'h0;
  localparam logic [28:0] PBA_OFF = ext_irq_enable ? pending_array_offset : 29'h0000_0000;
  localparam logic [2:0] TBL_BIR = ext_irq_enable ? vector_table_bar_indicator : 3'h0;
  localparam logic [28:0] TBL_OFF = ext_irq_enable ? vector_table_offset : 29'h0000_0000;
  localparam logic [10:0] TBL_SIZE = ext_irq_enable ? vector_table_size : 11'h000;

  logic [2:0] l0s_now;
  logic [2:0] l1_now;
  logic [31:0] next_rdata;

  always_comb begin
    l0s_now = pick_latency(cfg.link_rate, cfg.common_clk, L0S_COM_2G5, L0S_COM_5G,
      L0S_COM_8G, L0S_SEP_2G5, L0S_SEP_5G, L0S_SEP_8G);
    l1_now = pick_latency(cfg.link_rate, cfg.common_clk, L1_COM_2G5, L1_COM_5G,
      L1_COM_8G, L1_SEP_2G5, L1_SEP_5G, L1_SEP_8G);
  end

  // Read decode; unmapped dwords read zero
  always_comb begin
    next_rdata = pcfm_pkg::ZERO_WORD;
    if (cfg.addr == pcfm_pkg::LINK_CAP_DW) begin
      next_rdata[pcfm_pkg::L0S_LSB +: 3] = l0s_now;
      next_rdata[pcfm_pkg::L1_LSB +: 3] = l1_now;
    end else if (cfg.addr == pcfm_pkg::DEV_CAP2_DW) begin
      next_rdata[pcfm_pkg::CTO_OFF_BIT] = completion_timeout_off_capable;
      next_rdata[pcfm_pkg::ATOM32_BIT] = atomic32_completer;
      next_rdata[pcfm_pkg::ATOM64_BIT] = atomic64_completer;
      next_rdata[pcfm_pkg::CAS128_BIT] = cas128_completer;
      next_rdata[pcfm_pkg::LTR_BIT] = latency_tolerance_supported;
      next_rdata[pcfm_pkg::TPH_BIT] = hint_completer_supported;
      // Wake-pin codes are not supported, so only the low bit is honoured
      next_rdata[pcfm_pkg::OBFF_LSB +: 2] = {1'b0, flush_fill_hint_support[0]};
    end else if (cfg.addr == pcfm_pkg::MSI_CAP_DW) begin
      next_rdata[15:0] = {msg_irq_next_pointer, pcfm_pkg::MSI_ID};
      // Reserved request codes are clamped to the 32-vector maximum
      next_rdata[pcfm_pkg::MSI_VEC_LSB +: 3] =
        (msg_irq_vector_request > 3'h5) ? 3'h5 : msg_irq_vector_request;
    end else if (cfg.addr == pcfm_pkg::MSIX_CAP_DW) begin
      next_rdata[15:0] = {ext_irq_next_pointer, pcfm_pkg::MSIX_ID};
      next_rdata[pcfm_pkg::MSIX_SIZE_LSB +: 11] = TBL_SIZE;
    end else if (cfg.addr == pcfm_pkg::MSIX_TBL_DW) begin
      next_rdata = {TBL_OFF, TBL_BIR};
    end else if (cfg.addr == pcfm_pkg::MSIX_PBA_DW) begin
      next_rdata = {PBA_OFF, PBA_BIR};
    end else if (cfg.addr == pcfm_pkg::PM_CAP_DW) begin
      next_rdata[15:0] = {power_cap_next_pointer, power_cap_identifier};
      next_rdata[pcfm_pkg::PMC_LSB +: 3] = power_cap_spec_version;
      next_rdata[pcfm_pkg::PME_D3HOT_BIT] = wake_from_d3hot;
      next_rdata[pcfm_pkg::PME_D1_BIT] = wake_from_d1;
      next_rdata[pcfm_pkg::PME_D0_BIT] = wake_from_d0;
      next_rdata[pcfm_pkg::D1_SUPP_BIT] = d1_state_supported;
    end else if (cfg.addr == pcfm_pkg::PM_CSR_DW) begin
      next_rdata[pcfm_pkg::NO_SOFT_RST_BIT] = keeps_state_on_d3_exit;
    end else if (resizable_bar_enable) begin
      if (cfg.addr == pcfm_pkg::RBAR_HDR_DW) begin
        next_rdata[15:0] = pcfm_pkg::RBAR_ID;
        next_rdata[pcfm_pkg::RBAR_VER_LSB +: 4] = resizable_bar_version;
        next_rdata[pcfm_pkg::RBAR_NEXT_LSB +: 12] = resizable_bar_next_pointer;
      end else if (cfg.addr == pcfm_pkg::RBAR_CAP0_DW) begin
        // Sizes land at [23:4], leaving [3:0] and [31:24] zero
        next_rdata[pcfm_pkg::RBAR_SIZE_LSB +: 20] = resizable_bar_sizes_first;
      end else if (cfg.addr == pcfm_pkg::RBAR_CTL0_DW) begin
        next_rdata[pcfm_pkg::RBAR_COUNT_LSB +: 3] = resizable_bar_count;
        next_rdata[2:0] = resizable_bar_index_first;
      end else if (cfg.addr == pcfm_pkg::RBAR_CAP1_DW) begin
        next_rdata[pcfm_pkg::RBAR_SIZE_LSB +: 20] = resizable_bar_sizes_second;
      end else if (cfg.addr == pcfm_pkg::RBAR_CTL1_DW) begin
        next_rdata[2:0] = resizable_bar_index_second;
      end
    end
  end

  // Every access is answered one cycle later; writes are acknowledged and dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.ack <= 1'b0;
    end else begin
      cfg.ack <= cfg.req & ~cfg.ack;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.rdata <= pcfm_pkg::ZERO_WORD;
    end else if (cfg.req && !cfg.ack) begin
      cfg.rdata <= cfg.we ? pcfm_pkg::ZERO_WORD : next_rdata;
    end
  end

endmodule // pcfm_field_map

//--- verilog/pcfm_cfg_ctrl.sv
// Configuration access controller: APB registers drive reads of the field map
`timescale 1ns/1ps
module pcfm_cfg_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pcfm_cfg_if.ctl cfg
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_WAIT = 2'b10
  } pcfm_ctl_e;

  pcfm_ctl_e state;
  logic [31:0] rdata_q;
  logic done;
  logic setup;
  logic wr;
  logic go;
  logic [31:0] next_prdata;
  logic next_slverr;

  assign setup = psel & ~penable & ~pready;
  // Writes land on the edge that completes the access, where the master sees pready
  assign wr = psel & penable & pready & pwrite;
  assign go = wr && paddr == pcfm_pkg::REG_CMD && pwdata[pcfm_pkg::CMD_GO_BIT] &&
    state == ST_IDLE;

  always_comb begin
    next_prdata = pcfm_pkg::ZERO_WORD;
    next_slverr = 1'b0;
    unique case (paddr)
      pcfm_pkg::REG_CMD: next_prdata = {15'h0000, cfg.we, 6'h00, cfg.addr};
      pcfm_pkg::REG_WDATA: next_prdata = cfg.wdata;
      pcfm_pkg::REG_RDATA: next_prdata = rdata_q;
      pcfm_pkg::REG_STATUS: next_prdata = {30'h0000_0000, done, state != ST_IDLE};
      pcfm_pkg::REG_LINK: next_prdata = {29'h0000_0000, cfg.common_clk, cfg.link_rate};
      default: next_slverr = 1'b1;
    endcase
  end

  // No wait state: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= pcfm_pkg::ZERO_WORD;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? next_prdata : pcfm_pkg::ZERO_WORD;
      pslverr <= setup & next_slverr;
    end
  end

  // Command, data and link setting registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.addr <= 10'h000;
      cfg.we <= 1'b0;
      cfg.wdata <= pcfm_pkg::ZERO_WORD;
      cfg.link_rate <= pcfm_pkg::RATE_2G5;
      cfg.common_clk <= 1'b0;
    end else begin
      if (go) begin
        cfg.addr <= pwdata[9:0];
        cfg.we <= pwdata[pcfm_pkg::CMD_WE_BIT];
      end
      if (wr && paddr == pcfm_pkg::REG_WDATA && state == ST_IDLE) begin
        cfg.wdata <= pwdata;
      end
      if (wr && paddr == pcfm_pkg::REG_LINK) begin
        cfg.link_rate <= pwdata[1:0];
        cfg.common_clk <= pwdata[pcfm_pkg::LINK_COMCLK_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cfg.req <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: if (go) begin
          state <= ST_REQ;
          cfg.req <= 1'b1;
        end
        ST_REQ: if (cfg.ack) begin
          state <= ST_WAIT;
          cfg.req <= 1'b0;
        end
        ST_WAIT: state <= ST_IDLE;
        default: begin
          state <= ST_IDLE;
          cfg.req <= 1'b0;
        end
      endcase
    end
  end

  // Completion wins over a simultaneous write-one clear of done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= pcfm_pkg::ZERO_WORD;
      done <= 1'b0;
    end else if (state == ST_REQ && cfg.ack) begin
      rdata_q <= cfg.rdata;
      done <= 1'b1;
    end else if (wr && paddr == pcfm_pkg::REG_STATUS && pwdata[pcfm_pkg::ST_DONE_BIT]) begin
      done <= 1'b0;
    end
  end

endmodule // pcfm_cfg_ctrl

//--- tb/pcfm_link_properties.sv
// Concurrent checks on the configuration link between controller and field map
`timescale 1ns/1ps
module pcfm_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic we,
  input wire logic [9:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata,
  input wire logic [1:0] link_rate,
  input wire logic common_clk
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd_ack;
  assign rd_ack = ack && !we;
  a_ack_one_pulse: assert property (req && !ack |=> ack ##1 !ack)
    else $error("ack is not a single pulse one cycle after a request");
  a_req_held_steady: assert property (req && !ack |=>
    $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before its acknowledge");
  a_rdata_holds: assert property (!req |=> $stable(rdata))
    else $error("read data moved without an access");
  a_write_no_effect: assert property (ack && we |-> rdata == pcfm_pkg::ZERO_WORD)
    else $error("write to a read-only field returned data");
  a_link_fields_only: assert property (rd_ack && addr == pcfm_pkg::LINK_CAP_DW |->
    rdata[11:0] == 12'h000 && rdata[31:18] == 14'h0000)
    else $error("link capability has bits outside the latency fields");
  a_hint_codes: assert property (rd_ack && addr == pcfm_pkg::DEV_CAP2_DW |->
    !rdata[pcfm_pkg::OBFF_LSB + 1] && !rdata[pcfm_pkg::TPH_BIT + 1])
    else $error("unsupported hint encoding advertised");
  a_vector_code: assert property (rd_ack && addr == pcfm_pkg::MSI_CAP_DW |->
    rdata[pcfm_pkg::MSI_VEC_LSB +: 3] <= 3'h5 && rdata[7:0] == pcfm_pkg::MSI_ID)
    else $error("vector request code out of range");
  a_pm_csr_bits: assert property (rd_ack && addr == pcfm_pkg::PM_CSR_DW |->
    (rdata & 32'hFFFF_FFF7) == pcfm_pkg::ZERO_WORD)
    else $error("power control word has bits other than no soft reset");
  a_rbar_header: assert property (rd_ack && addr == pcfm_pkg::RBAR_HDR_DW |->
    rdata[15:0] == pcfm_pkg::RBAR_ID || rdata == pcfm_pkg::ZERO_WORD)
    else $error("resizable bar header malformed");
  a_rbar_ctl_count: assert property (rd_ack && addr == pcfm_pkg::RBAR_CTL0_DW |->
    rdata[31:8] == 24'h000000 && rdata[4:3] == 2'h0)
    else $error("resizable bar control word malformed");
  c_write: cover property (ack && we);
  c_common_link: cover property (rd_ack && addr == pcfm_pkg::LINK_CAP_DW && common_clk);
  c_rbar: cover property (rd_ack && addr == pcfm_pkg::RBAR_HDR_DW);
endmodule // pcfm_link_properties

//--- tb/testbench.sv
// Self-checking bench: APB controller and field map joined by the config link
`timescale 1ns/1ps
module testbench;
  // Latency settings, common clock at rates 0..2 then separate clock
  localparam logic [17:0] L0S = 18'h358D1;
  localparam logic [17:0] L1 = 18'h0A777;
  // Capability settings handed to the map; the expected rows follow from them
  localparam logic [7:0] DC2 = 8'h7F; // Timeout off, atomics, tolerance, hint, flush/fill
  localparam logic [7:0] FLG = 8'h7D; // Wake D3hot/D0, D1, keep state, resizable, ext irq
  localparam logic [31:0] PTR = 32'h7000_4801; // Next pointers and power identifier
  localparam logic [31:0] TBL = {29'h1234567, 3'h2};
  localparam logic [31:0] PBA = {29'h0ABCDEF, 3'h5};
  localparam logic [23:0] MISC = {4'h1, 3'h2, 3'h3, 3'h5, 11'h7FF};
  localparam logic [11:0] RNEXT = 12'h000;
  localparam logic [2:0] RIDX_FIRST = 3'h1;
  localparam logic [2:0] RIDX_SECOND = 3'h3;
  localparam logic [39:0] RSIZES = {20'h00010, 20'hFFFFF};
  logic pclk;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [31:0] expq [$];
  int errors, comparisons;
  pcfm_cfg_if cfg_bus ();
  pcfm_cfg_ctrl u_pcfm_cfg_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg(cfg_bus));
  pcfm_field_map #(
    .L0S_COM_2G5(L0S[2:0]), .L0S_COM_5G(L0S[5:3]), .L0S_COM_8G(L0S[8:6]),
    .L0S_SEP_2G5(L0S[11:9]), .L0S_SEP_5G(L0S[14:12]), .L0S_SEP_8G(L0S[17:15]),
    .L1_COM_2G5(L1[2:0]), .L1_COM_5G(L1[5:3]), .L1_COM_8G(L1[8:6]),
    .L1_SEP_2G5(L1[11:9]), .L1_SEP_5G(L1[14:12]), .L1_SEP_8G(L1[17:15]),
    .completion_timeout_off_capable(DC2[0]), .atomic32_completer(DC2[1]),
    .atomic64_completer(DC2[2]), .cas128_completer(DC2[3]),
    .latency_tolerance_supported(DC2[4]), .hint_completer_supported(DC2[5]),
    .flush_fill_hint_support(DC2[7:6]), .msg_irq_next_pointer(PTR[31:24]),
    .msg_irq_vector_request(MISC[13:11]), .ext_irq_enable(FLG[6]),
    .ext_irq_next_pointer(PTR[23:16]), .pending_array_bar_indicator(PBA[2:0]),
    .pending_array_offset(PBA[31:3]), .vector_table_bar_indicator(TBL[2:0]),
    .vector_table_offset(TBL[31:3]), .vector_table_size(MISC[10:0]),
    .power_cap_identifier(PTR[7:0]), .power_cap_next_pointer(PTR[15:8]),
    .power_cap_spec_version(MISC[16:14]), .wake_from_d3hot(FLG[0]),
    .wake_from_d1(FLG[1]), .wake_from_d0(FLG[2]), .d1_state_supported(FLG[3]),
    .keeps_state_on_d3_exit(FLG[4]), .resizable_bar_enable(FLG[5]),
    .resizable_bar_version(MISC[23:20]), .resizable_bar_next_pointer(RNEXT),
    .resizable_bar_count(MISC[19:17]), .resizable_bar_index_first(RIDX_FIRST),
    .resizable_bar_index_second(RIDX_SECOND), .resizable_bar_sizes_first(RSIZES[19:0]),
    .resizable_bar_sizes_second(RSIZES[39:20])
  ) u_pcfm_field_map (.pclk(pclk), .presetn(presetn), .cfg(cfg_bus));
  pcfm_link_properties u_pcfm_link_properties (.pclk(pclk), .presetn(presetn),
    .req(cfg_bus.req), .we(cfg_bus.we), .addr(cfg_bus.addr), .wdata(cfg_bus.wdata),
    .ack(cfg_bus.ack), .rdata(cfg_bus.rdata), .link_rate(cfg_bus.link_rate),
    .common_clk(cfg_bus.common_clk));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen at a rising edge, then releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic access(input logic [9:0] idx, input logic w, input logic [31:0] exp);
    logic [31:0] st;
    logic e;
    int n;
    n = 0;
    expq.push_back(exp);
    apb(1'b1, pcfm_pkg::REG_CMD, 32'h8000_0000 | {15'h0, w, 6'h00, idx}, st, e);
    do begin
      apb(1'b0, pcfm_pkg::REG_STATUS, 32'h0, st, e);
      n++;
    end while (st[pcfm_pkg::ST_DONE_BIT] !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    apb(1'b1, pcfm_pkg::REG_STATUS, 32'h0000_0002, st, e);
    apb(1'b0, pcfm_pkg::REG_RDATA, 32'h0, st, e);
    check(st, exp);
  endtask
  // Random write first, so the read shows that writes leave the field alone
  task automatic row(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    seed = lfsr(seed);
    apb(1'b1, pcfm_pkg::REG_WDATA, seed, r, e);
    access(idx, 1'b1, 32'h0000_0000);
    access(idx, 1'b0, exp);
  endtask
  always @(posedge pclk) begin
    if (cfg_bus.ack === 1'b1 && expq.size() > 0) check(cfg_bus.rdata, expq.pop_front());
    else if (cfg_bus.ack === 1'b1) check(cfg_bus.rdata, ~cfg_bus.rdata);
  end
  task automatic conclude();
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    conclude();
  end
  initial begin
    int k;
    logic [31:0] r;
    logic e;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    errors = 0;
    comparisons = 0;
    seed = 32'h316509EB;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Rate code 3 is taken as the lowest rate
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, pcfm_pkg::REG_LINK, {29'h0, m[2], m[1:0]}, r, e);
      k = (m[2] ? 0 : 3) + (m[1:0] == 2'b11 ? 0 : m[1:0]);
      access(pcfm_pkg::LINK_CAP_DW, 1'b0,
        {14'h0, L1[k*3 +: 3], L0S[k*3 +: 3], 12'h000});
    end
    row(pcfm_pkg::PM_CAP_DW, 32'h4A03_4801);
    row(pcfm_pkg::PM_CSR_DW, 32'h0000_0008);
    row(pcfm_pkg::MSI_CAP_DW, 32'h000A_7005);
    row(pcfm_pkg::MSIX_CAP_DW, 32'h07FF_0011);
    row(pcfm_pkg::MSIX_TBL_DW, TBL);
    row(pcfm_pkg::MSIX_PBA_DW, PBA);
    row(pcfm_pkg::DEV_CAP2_DW, 32'h0004_1B90);
    row(pcfm_pkg::RBAR_HDR_DW, 32'h0001_0015);
    row(pcfm_pkg::RBAR_CAP0_DW, 32'h00FF_FFF0);
    row(pcfm_pkg::RBAR_CTL0_DW, 32'h0000_0041);
    row(pcfm_pkg::RBAR_CAP1_DW, 32'h0000_0100);
    row(pcfm_pkg::RBAR_CTL1_DW, 32'h0000_0003);
    row(10'h3FF, 32'h0000_0000);
    // Unmapped register address must be refused
    apb(1'b0, 8'h40, 32'h0, r, e);
    check({31'h0, e}, 32'h0000_0001);
    check(r, 32'h0000_0000);
    repeat (5) @(posedge pclk);
    check(32'(expq.size()), 32'h0000_0000);
    conclude();
  end
endmodule // testbench
